// >>> design/link_cap_ctl_regs.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Link capability bits 3:0 always read 0001, a 2.5 Gb/s link.
// - Bits 9:4 report maximum width in the one-hot-like code, x1 (000001) from reset.
// - Bits 11:10 read 11, both L0s and L1 supported.
// - Bits 17:15 read 6h when the strap enabled clock power management, else 0h.
// - Bit 18 reads 1 when the strap enabled clock power management, else 0.
// - Link control bits 1:0 are read-write power state entry control, reset 00.
// - Link control bit 3 always reads 0.
// - Link control bit 8 is writable only with the strap on, else reads 0; reset 0.
module link_cap_ctl_regs
    import link_regs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // strap pins, sampled at reset release
    input wire logic [1:0] req_strap_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // state seen by the link logic
    output logic [1:0] pm_ctl_o,
    output logic clkpm_en_o,
    output logic clkpm_cap_o
);
    typedef enum logic {
        STRAP_WAIT,
        STRAP_HELD
    } strap_phase_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_CAP,
        SRC_CTL
    } rd_src_t;

    // reset release
    logic rst_q1;
    logic rst_n;
    logic next_rst_q1;
    logic next_rst_n;
    // strap capture
    strap_phase_t strap_phase;
    strap_phase_t next_strap_phase;
    logic strap_on;
    logic next_strap_on;
    // address decode
    logic hit_cap;
    logic hit_ctl;
    logic cap_rd;
    logic ctl_rd;
    logic ctl_wr;
    // capability fields
    logic [3:0] speed_field;
    logic [5:0] width_field;
    logic [1:0] pm_sup_field;
    logic [2:0] l0s_lat_field;
    logic [2:0] l1_lat_field;
    logic clkpm_cap_field;
    logic dll_rep_field;
    logic [7:0] port_field;
    logic [31:0] cap_word;
    // read path and link-side copies
    rd_src_t rd_src;
    logic [31:0] ctl_word;
    logic [31:0] next_rdata;
    logic [1:0] next_pm_mirror;
    logic next_en_mirror;
    logic next_cap_mirror;
    ctl_if cbus ();

    // two-stage release so the core leaves reset on a clean edge
    always_comb begin
        next_rst_q1 = 1'h1;
        next_rst_n = rst_q1;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_q1 <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_q1 <= next_rst_q1;
            rst_n <= next_rst_n;
        end
    end

    // strap caught on the first clock after release, then frozen until the
    // next reset; later pin movement must not flip the capability
    always_comb begin
        next_strap_phase = strap_phase;
        next_strap_on = strap_on;
        unique case (strap_phase)
            STRAP_WAIT: begin
                next_strap_on = (req_strap_n_i == 2'h0);
                next_strap_phase = STRAP_HELD;
            end
            STRAP_HELD: begin
                next_strap_on = strap_on;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_phase <= STRAP_WAIT;
            strap_on <= 1'h0;
        end else begin
            strap_phase <= next_strap_phase;
            strap_on <= next_strap_on;
        end
    end

    // exact byte match; a partial decode would alias into unmapped space
    always_comb begin
        hit_cap = (addr_i == LINK_CAP_OFS);
        hit_ctl = (addr_i == LINK_CTL_OFS);
        cap_rd = rd_i && hit_cap;
        ctl_rd = rd_i && hit_ctl;
        ctl_wr = wr_i && hit_ctl;
    end

    // hard-wired fields; width stays x1 as no wider lane set exists here
    always_comb begin
        speed_field = MAX_SPEED_CODE;
        width_field = MAX_WIDTH_RESET;
        pm_sup_field = PM_SUPPORT_CODE;
        l0s_lat_field = L0S_EXIT_LAT;
        dll_rep_field = DLL_ACTIVE_REPORT;
        port_field = PORT_NUMBER;
    end

    // strap-derived fields
    always_comb begin
        l1_lat_field = L1_EXIT_LAT_OFF;
        clkpm_cap_field = 1'h0;
        if (strap_on) begin
            l1_lat_field = L1_EXIT_LAT_ON;
            clkpm_cap_field = 1'h1;
        end
    end

    // no write path into this word; reserved bits stay zero
    always_comb begin
        cap_word = '0;
        cap_word[SPEED_LSB +: 4] = speed_field;
        cap_word[WIDTH_LSB +: 6] = width_field;
        cap_word[PM_SUP_LSB +: 2] = pm_sup_field;
        cap_word[L0S_LAT_LSB +: 3] = l0s_lat_field;
        cap_word[L1_LAT_LSB +: 3] = l1_lat_field;
        cap_word[CLKPM_CAP_BIT] = clkpm_cap_field;
        cap_word[DLL_REP_BIT] = dll_rep_field;
        cap_word[PORT_LSB +: 8] = port_field;
    end

    // writes reach the control register only on an exact hit
    assign cbus.wr = ctl_wr;
    assign cbus.wdata = wdata_i[15:0];
    assign cbus.strap_on = strap_on;

    link_ctl_reg u_ctl (
        .clk_i(clk_i),
        .nrst_i(rst_n),
        .bus(cbus.slave)
    );

    // upper half of the control word has no storage
    always_comb begin
        ctl_word = '0;
        ctl_word[15:0] = cbus.ctl;
    end

    // one source per read; reads elsewhere fall to zero
    always_comb begin
        rd_src = SRC_NONE;
        if (cap_rd) begin
            rd_src = SRC_CAP;
        end else if (ctl_rd) begin
            rd_src = SRC_CTL;
        end
    end

    // idle cycles return zero so a stale word never lingers on the port
    always_comb begin
        next_rdata = '0;
        unique case (rd_src)
            SRC_NONE: next_rdata = '0;
            SRC_CAP: next_rdata = cap_word;
            SRC_CTL: next_rdata = ctl_word;
            default: next_rdata = '0;
        endcase
    end

    // read word stands for one clock only
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // link-side copies lag the register by one clock
    always_comb begin
        next_pm_mirror = cbus.ctl[PM_CTL_LSB +: 2];
        next_en_mirror = cbus.ctl[CLKPM_EN_BIT];
        next_cap_mirror = strap_on;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pm_ctl_o <= PM_CTL_RESET;
            clkpm_en_o <= 1'h0;
            clkpm_cap_o <= 1'h0;
        end else begin
            pm_ctl_o <= next_pm_mirror;
            clkpm_en_o <= next_en_mirror;
            clkpm_cap_o <= next_cap_mirror;
        end
    end
endmodule

// >>> design/link_ctl_reg.sv
`timescale 1ns/1ps
module link_ctl_reg
    import link_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    ctl_if.slave bus
);
    logic [1:0] pm_ctl;
    logic common_clk;
    logic ext_sync;
    logic clkpm_en;
    logic [1:0] next_pm_ctl;
    logic next_common_clk;
    logic next_ext_sync;
    logic next_clkpm_en;

    always_comb begin
        next_pm_ctl = pm_ctl;
        next_common_clk = common_clk;
        next_ext_sync = ext_sync;
        next_clkpm_en = clkpm_en;
        if (bus.wr) begin
            next_pm_ctl = bus.wdata[PM_CTL_LSB +: 2];
            next_common_clk = bus.wdata[COMMON_CLK_BIT];
            next_ext_sync = bus.wdata[EXT_SYNC_BIT];
            next_clkpm_en = bus.wdata[CLKPM_EN_BIT] & bus.strap_on;
        end
        if (!bus.strap_on) begin
            next_clkpm_en = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pm_ctl <= PM_CTL_RESET;
            common_clk <= 1'b0;
            ext_sync <= 1'b0;
            clkpm_en <= 1'b0;
        end else begin
            pm_ctl <= next_pm_ctl;
            common_clk <= next_common_clk;
            ext_sync <= next_ext_sync;
            clkpm_en <= next_clkpm_en;
        end
    end

    // rcb, link disable, retrain and reserved bits stay zero
    always_comb begin
        bus.ctl = '0;
        bus.ctl[PM_CTL_LSB +: 2] = pm_ctl;
        bus.ctl[RCB_BIT] = 1'b0;
        bus.ctl[COMMON_CLK_BIT] = common_clk;
        bus.ctl[EXT_SYNC_BIT] = ext_sync;
        bus.ctl[CLKPM_EN_BIT] = clkpm_en;
    end
endmodule

// >>> include/ctl_if.sv
`timescale 1ns/1ps
interface ctl_if;
    logic wr;
    logic [15:0] wdata;
    logic strap_on;
    logic [15:0] ctl;
    modport master (output wr, output wdata, output strap_on, input ctl);
    modport slave (input wr, input wdata, input strap_on, output ctl);
endinterface

// >>> include/link_regs_pkg.sv
package link_regs_pkg;
    localparam logic [7:0] LINK_CAP_OFS = 8'hbc;
    localparam logic [7:0] LINK_CTL_OFS = 8'hc0;
    localparam logic [3:0] MAX_SPEED_CODE = 4'h1;
    localparam logic [5:0] MAX_WIDTH_RESET = 6'h01;
    localparam logic [1:0] PM_SUPPORT_CODE = 2'h3;
    localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
    localparam logic [2:0] L1_EXIT_LAT_ON = 3'h6;
    localparam logic [2:0] L1_EXIT_LAT_OFF = 3'h0;
    localparam logic [7:0] PORT_NUMBER = 8'h00;
    localparam logic DLL_ACTIVE_REPORT = 1'b0;
    localparam logic [1:0] PM_CTL_RESET = 2'h0;
    localparam int SPEED_LSB = 0;
    localparam int WIDTH_LSB = 4;
    localparam int PM_SUP_LSB = 10;
    localparam int L0S_LAT_LSB = 12;
    localparam int L1_LAT_LSB = 15;
    localparam int CLKPM_CAP_BIT = 18;
    localparam int DLL_REP_BIT = 20;
    localparam int PORT_LSB = 24;
    localparam int PM_CTL_LSB = 0;
    localparam int RCB_BIT = 3;
    localparam int COMMON_CLK_BIT = 6;
    localparam int EXT_SYNC_BIT = 7;
    localparam int CLKPM_EN_BIT = 8;
endpackage

// >>> tb/link_regs_chk_asserts.sv
`timescale 1ns/1ps
module link_regs_chk
    import link_regs_pkg::*;
(
    // watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] pm_ctl_o,
    input wire logic clkpm_en_o,
    input wire logic clkpm_cap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence cap_rd;
        rd_i && addr_i == LINK_CAP_OFS;
    endsequence
    sequence ctl_rd;
        rd_i && addr_i == LINK_CTL_OFS;
    endsequence
    // outputs copy the register one edge late
    sequence ctl_wr;
        wr_i && addr_i == LINK_CTL_OFS ##1 1;
    endsequence
    a_speed_code: assert property (cap_rd |=> rdata_o[3:0] == MAX_SPEED_CODE)
        else $error("speed code wrong");
    a_width_code: assert property (cap_rd |=> rdata_o[9:4] == MAX_WIDTH_RESET)
        else $error("width code wrong");
    a_pm_support: assert property (cap_rd |=> rdata_o[11:10] == PM_SUPPORT_CODE)
        else $error("pm support wrong");
    a_l1_latency: assert property (cap_rd |=> rdata_o[17:15] ==
        (clkpm_cap_o ? L1_EXIT_LAT_ON : L1_EXIT_LAT_OFF)) else $error("l1 latency wrong");
    a_cap_bit: assert property (cap_rd |=> rdata_o[18] == clkpm_cap_o)
        else $error("capable bit wrong");
    a_ro_zero: assert property (ctl_rd |=> rdata_o[5:2] == 0 && rdata_o[31:9] == 0)
        else $error("fixed control bits wrong");
    a_pm_write: assert property (ctl_wr |=> pm_ctl_o == $past(wdata_i[1:0], 2))
        else $error("pm control not written");
    a_en_gate: assert property (ctl_wr |=>
        clkpm_en_o == ($past(wdata_i[8], 2) && clkpm_cap_o)) else $error("enable gate wrong");
endmodule
bind link_cap_ctl_regs link_regs_chk u_chk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .pm_ctl_o(pm_ctl_o),
    .clkpm_en_o(clkpm_en_o),
    .clkpm_cap_o(clkpm_cap_o)
);

// >>> tb/serial_link_capability_control_regs_test.sv
`timescale 1ns/1ps
module serial_link_capability_control_regs_test;
    import link_regs_pkg::*;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, on = 0, clkpm_en_o, clkpm_cap_o;
    logic [1:0] req_strap_n_i, pm_ctl_o;
    logic [7:0] addr_i = 0;
    logic [31:0] wdata_i = 0, rdata_o;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    strap_model host (.on_i(on), .req_strap_n_o(req_strap_n_i));
    link_cap_ctl_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_strap_n_i(req_strap_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pm_ctl_o(pm_ctl_o), .clkpm_en_o(clkpm_en_o), .clkpm_cap_o(clkpm_cap_o));
    task automatic finish_test;
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 0;
        @(negedge clk_i);
        chk("rdata", e, rdata_o);
    endtask
    // strap only moves while reset is low
    task automatic t_reset(logic s);
        if (nrst_i) @(posedge clk_i);
        nrst_i <= 0;
        on <= s;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk("cap", s, clkpm_cap_o);
        rd(LINK_CTL_OFS, 32'h0);
    endtask
    task automatic t_cap(logic s);
        logic [31:0] c;
        c = {13'h0, s, s ? L1_EXIT_LAT_ON : L1_EXIT_LAT_OFF, L0S_EXIT_LAT,
            PM_SUPPORT_CODE, MAX_WIDTH_RESET, MAX_SPEED_CODE};
        rd(LINK_CAP_OFS, c);
        wr(LINK_CAP_OFS, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        wr(8'hc1, 32'hffff_ffff);
        rd(LINK_CAP_OFS, c);
        rd(8'h10, 32'h0);
        rd(LINK_CTL_OFS, 32'h0);
    endtask
    task automatic t_ctl(logic s);
        for (int i = 0; i < 4; i++) begin
            wr(LINK_CTL_OFS, 32'hffff_fffc | i);
            rd(LINK_CTL_OFS, {23'h0, s, 6'h30, i[1:0]});
            chk("pm_ctl", i, pm_ctl_o);
            chk("clkpm_en", s, clkpm_en_o);
        end
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        for (int s = 0; s < 2; s++) begin
            t_reset(s[0]);
            t_cap(s[0]);
            t_ctl(s[0]);
        end
        finish_test();
    end
endmodule

// >>> tb/strap_model.sv
`timescale 1ns/1ps
module strap_model (
    // strap choice
    input wire logic on_i,
    // strap pins
    output logic [1:0] req_strap_n_o
);
    // both pins low selects clock power management
    assign req_strap_n_o = on_i ? 2'h0 : 2'h3;
endmodule
